/* File: logic/gpirq_consts.svh */
// register offsets, field positions and reset values for the gpio interrupt port
`ifndef GPIRQ_CONSTS_SVH
`define GPIRQ_CONSTS_SVH
`define GPIRQ_OFS_EXP_MASK 4'h0
`define GPIRQ_OFS_EXP_STATUS 4'h1
`define GPIRQ_OFS_EXP_CONTROL 4'h2
`define GPIRQ_OFS_LINE_DIR 4'h3
`define GPIRQ_OFS_LINE_POL 4'h4
`define GPIRQ_OFS_LINE_OUT 4'h5
`define GPIRQ_OFS_LINE_IN 4'h6
`define GPIRQ_OFS_LINE_MASK 4'h7
`define GPIRQ_OFS_LINE_STATUS 4'h8
`define GPIRQ_EXP_MASK_BIT 0
`define GPIRQ_EXP_STATUS_BIT 0
`define GPIRQ_CTRL_EN_BIT 7
`define GPIRQ_CTRL_SEL_HI 6
`define GPIRQ_CTRL_SEL_LO 4
`define GPIRQ_RST_BYTE 8'h00
`define GPIRQ_RST_SEL 3'h0
`endif

/* File: logic/gpirq_pkg.sv */
// types shared by the gpio interrupt port
package gpirq_pkg;
  // serialized irq line choices, encoded as the select field
  typedef enum logic [2:0] {
    gpirq_irq3 = 3'b000,
    gpirq_irq4 = 3'b001,
    gpirq_irq5 = 3'b010,
    gpirq_irq10 = 3'b011,
    gpirq_irq6 = 3'b100,
    gpirq_irq7 = 3'b101,
    gpirq_irq9 = 3'b110,
    gpirq_irq11 = 3'b111
  } gpirq_line_sel_type;
  // pin side of the eight auxiliary lines
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpirq_pin_drive_type;
  // host interrupt routing
  typedef struct packed {
    logic req;
    gpirq_line_sel_type line;
  } gpirq_host_irq_type;
endpackage

/* File: logic/gpirq_sync_edge.sv */
// two-flop synchroniser with rising edge detect, one per bit
`timescale 1ns/1ps
module gpirq_sync_edge #(
  parameter int width = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // asynchronous inputs
  input wire logic [width-1:0] async_in,
  // synchronised level and rising edge pulse
  output logic [width-1:0] sync_out,
  output logic [width-1:0] rise_out
);
  logic [width-1:0] meta_q;
  logic [width-1:0] sync_q;
  logic [width-1:0] prev_q;

  // meta_q is read only by sync_q; the chain keeps sampling through reset, so the
  // edge history already matches the pin when reset lets go and no edge is invented
  always_ff @(posedge clk)
  begin
    meta_q <= async_in;
    sync_q <= meta_q;
    prev_q <= sync_q;
  end

  assign sync_out = sync_q;
  // no edge is reported while reset holds
  assign rise_out = sync_q & ~prev_q & {width{reset_n}};
endmodule

/* File: logic/gpirq_port.sv */
// gpio and expander interrupt port with avalon-mm register slave
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "gpirq_consts.svh"
module gpirq_port (
  // clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic power_on_reset_n,
  input wire logic power_retention_select,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // auxiliary lines
  input wire logic [7:0] line_pin_in,
  output gpirq_pkg::gpirq_pin_drive_type line_pin,
  // expander shared interrupt input
  input wire logic expander_irq_in,
  // interrupt requests
  output gpirq_pkg::gpirq_host_irq_type expander_host_irq,
  output logic line_irq
);
  logic [7:0] exp_mask_q;
  logic exp_status_q;
  logic host_irq_enable_q;
  gpirq_pkg::gpirq_line_sel_type host_irq_line_select_q;
  logic [7:0] line_direction_q;
  logic [7:0] line_polarity_q;
  logic [7:0] line_output_value_q;
  logic [7:0] line_irq_mask_q;
  logic [7:0] line_irq_status_q;
  logic [7:0] prev_state_q;
  logic [31:0] readdata_q;
  logic ack_q;
  logic cfg_reset_n;
  logic [7:0] pin_sync;
  logic [7:0] pin_state_bits;
  logic [7:0] line_event;
  logic exp_rise;
  logic wr_strobe;
  logic [7:0] wbyte;
  logic rd_legal;
  // decoded write strobes, one per writable register
  logic wr_exp_mask;
  logic wr_exp_status;
  logic wr_exp_control;
  logic wr_line_dir;
  logic wr_line_pol;
  logic wr_line_out;
  logic wr_line_mask;
  logic wr_line_status;
  // status set and clear terms
  logic exp_set;
  logic exp_clr;
  logic [7:0] line_clr;
  // request terms, pin level and read-back byte
  logic exp_req_d;
  logic line_req_d;
  logic [7:0] drive_level_d;
  logic [7:0] ctrl_byte;
  logic bus_access;

  // pins pass two flops before any logic looks at them
  gpirq_sync_edge #(.width(8)) u_line_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(line_pin_in),
    .sync_out(pin_sync),
    .rise_out()
  );

  gpirq_sync_edge #(.width(1)) u_exp_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(expander_irq_in),
    .sync_out(),
    .rise_out(exp_rise)
  );

  // any read or write still standing on the bus
  assign bus_access = avs_read | avs_write;

  // one wait cycle per access, then ack; keeps read data registered
  assign avs_waitrequest = bus_access & ~ack_q;
  assign wr_strobe = avs_write & ~ack_q;
  assign wbyte = avs_writedata[7:0];

  // write decode: the strobe is only high in the first cycle, so a write lands once
  always_comb
  begin
    wr_exp_mask = 1'b0;
    wr_exp_status = 1'b0;
    wr_exp_control = 1'b0;
    wr_line_dir = 1'b0;
    wr_line_pol = 1'b0;
    wr_line_out = 1'b0;
    wr_line_mask = 1'b0;
    wr_line_status = 1'b0;
    if (avs_address == `GPIRQ_OFS_EXP_MASK)
      wr_exp_mask = wr_strobe;
    else if (avs_address == `GPIRQ_OFS_EXP_STATUS)
      wr_exp_status = wr_strobe;
    else if (avs_address == `GPIRQ_OFS_EXP_CONTROL)
      wr_exp_control = wr_strobe;
    else if (avs_address == `GPIRQ_OFS_LINE_DIR)
      wr_line_dir = wr_strobe;
    else if (avs_address == `GPIRQ_OFS_LINE_POL)
      wr_line_pol = wr_strobe;
    else if (avs_address == `GPIRQ_OFS_LINE_OUT)
      wr_line_out = wr_strobe;
    else if (avs_address == `GPIRQ_OFS_LINE_MASK)
      wr_line_mask = wr_strobe;
    else if (avs_address == `GPIRQ_OFS_LINE_STATUS)
      wr_line_status = wr_strobe;
    // the read-back word and unmapped words take no write
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ack_q <= 1'b0;
    else
      ack_q <= bus_access & ~ack_q;
  end

  // retention select picks power-on only or power-on plus platform reset
  assign cfg_reset_n = power_on_reset_n & (power_retention_select | reset_n);

  // expander mask: only bit zero is stored, platform reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      exp_mask_q <= `GPIRQ_RST_BYTE;
    else if (wr_exp_mask)
      exp_mask_q <= {7'h00, wbyte[`GPIRQ_EXP_MASK_BIT]};
  end

  // set and clear terms of the expander status; writing zero leaves it alone
  assign exp_set = exp_rise;
  assign exp_clr = wr_exp_status & wbyte[`GPIRQ_EXP_STATUS_BIT];

  // expander status: a new edge beats a clear in the same cycle, so no event is lost
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      exp_status_q <= 1'b0;
    else if (exp_set)
      exp_status_q <= 1'b1;
    else if (exp_clr)
      exp_status_q <= 1'b0;
  end

  // expander control: enable and serialized irq line select
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      host_irq_enable_q <= 1'b0;
      host_irq_line_select_q <= gpirq_pkg::gpirq_line_sel_type'(`GPIRQ_RST_SEL);
    end
    else if (wr_exp_control)
    begin
      host_irq_enable_q <= wbyte[`GPIRQ_CTRL_EN_BIT];
      host_irq_line_select_q <=
        gpirq_pkg::gpirq_line_sel_type'(wbyte[`GPIRQ_CTRL_SEL_HI:`GPIRQ_CTRL_SEL_LO]);
    end
  end

  // line direction survives platform reset when retention is selected
  always_ff @(posedge clk)
  begin
    if (!cfg_reset_n)
      line_direction_q <= `GPIRQ_RST_BYTE;
    else if (wr_line_dir)
      line_direction_q <= wbyte;
  end

  // line polarity, same retention as direction
  always_ff @(posedge clk)
  begin
    if (!cfg_reset_n)
      line_polarity_q <= `GPIRQ_RST_BYTE;
    else if (wr_line_pol)
      line_polarity_q <= wbyte;
  end

  // stored output value; read back as written, never as the pin level
  always_ff @(posedge clk)
  begin
    if (!cfg_reset_n)
      line_output_value_q <= `GPIRQ_RST_BYTE;
    else if (wr_line_out)
      line_output_value_q <= wbyte;
  end

  // line mask always follows platform reset, so it is set up again after sleep
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      line_irq_mask_q <= `GPIRQ_RST_BYTE;
    else if (wr_line_mask)
      line_irq_mask_q <= wbyte;
  end

  // polarised pin state; an inverted line asserts when low
  assign pin_state_bits = pin_sync ^ line_polarity_q;

  // edge of the polarised state, so inversion turns rising into falling;
  // in reset it follows the state, so a line already asserted shows no edge at release
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      prev_state_q <= pin_state_bits;
    else
      prev_state_q <= pin_state_bits;
  end

  // a polarity change may itself flag an edge; software should clear after
  assign line_event = pin_state_bits & ~prev_state_q;

  // write-one-clear term per line; zero bits leave their line alone
  assign line_clr = {8{wr_line_status}} & wbyte;

  // per-line status: set wins over write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_line_status
      always_ff @(posedge clk)
      begin
        if (!reset_n)
          line_irq_status_q[gi] <= 1'b0;
        else if (line_event[gi])
          line_irq_status_q[gi] <= 1'b1;
        else if (line_clr[gi])
          line_irq_status_q[gi] <= 1'b0;
      end
    end
  endgenerate

  // asserted value turned into a pin level; an inverted line asserts low
  assign drive_level_d = line_output_value_q ^ line_polarity_q;

  // pin drive registered so the pins do not glitch on decode
  always_ff @(posedge clk)
  begin
    if (!cfg_reset_n)
      line_pin <= '0;
    else
    begin
      line_pin.out <= drive_level_d;
      line_pin.oe <= line_direction_q;
    end
  end

  // one request stands for all 32 expander lines, gated by mask and enable
  assign exp_req_d = exp_status_q & exp_mask_q[`GPIRQ_EXP_MASK_BIT] &
                     host_irq_enable_q;
  // any line whose status and mask are both set asks for service
  assign line_req_d = |(line_irq_status_q & line_irq_mask_q);

  // expander request and its line choice, registered so the host sees no decode glitch
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      expander_host_irq <= '0;
    else
    begin
      expander_host_irq.req <= exp_req_d;
      expander_host_irq.line <= host_irq_line_select_q;
    end
  end

  // line request, registered
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      line_irq <= 1'b0;
    else
      line_irq <= line_req_d;
  end

  // control byte as read back; bits three to zero are reserved and read zero
  assign ctrl_byte = {host_irq_enable_q, host_irq_line_select_q, 4'h0};

  // read decode; unmapped offsets read zero
  assign rd_legal = avs_read & ~ack_q;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      readdata_q <= 32'h0000_0000;
    else if (rd_legal)
    begin
      if (avs_address == `GPIRQ_OFS_EXP_MASK)
        readdata_q <= {24'h000000, exp_mask_q};
      else if (avs_address == `GPIRQ_OFS_EXP_STATUS)
        readdata_q <= {31'h00000000, exp_status_q};
      else if (avs_address == `GPIRQ_OFS_EXP_CONTROL)
        readdata_q <= {24'h000000, ctrl_byte};
      else if (avs_address == `GPIRQ_OFS_LINE_DIR)
        readdata_q <= {24'h000000, line_direction_q};
      else if (avs_address == `GPIRQ_OFS_LINE_POL)
        readdata_q <= {24'h000000, line_polarity_q};
      else if (avs_address == `GPIRQ_OFS_LINE_OUT)
        readdata_q <= {24'h000000, line_output_value_q};
      else if (avs_address == `GPIRQ_OFS_LINE_IN)
        readdata_q <= {24'h000000, pin_state_bits};
      else if (avs_address == `GPIRQ_OFS_LINE_MASK)
        readdata_q <= {24'h000000, line_irq_mask_q};
      else if (avs_address == `GPIRQ_OFS_LINE_STATUS)
        readdata_q <= {24'h000000, line_irq_status_q};
      else
        readdata_q <= 32'h0000_0000;
    end
  end

  assign avs_readdata = readdata_q;
endmodule

/* File: verif/gpirq_port_asserts.sv */
// concurrent checks on the gpio interrupt port pins
`timescale 1ns/1ps
module gpirq_port_asserts (
  // clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic power_on_reset_n,
  input wire logic power_retention_select,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins and requests
  input wire logic [7:0] line_pin_in,
  input wire gpirq_pkg::gpirq_pin_drive_type line_pin,
  input wire logic expander_irq_in,
  input wire gpirq_pkg::gpirq_host_irq_type expander_host_irq,
  input wire logic line_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // first cycle of a write; registers land here, pins one edge later
  sequence wr_take(logic [3:0] a);
    avs_write && avs_waitrequest && avs_address == a;
  endsequence
  sel_copy_a: assert property (wr_take(4'h2) |=> ##1
    expander_host_irq.line == $past(avs_writedata[6:4])) else $error("irq line copy wrong");
  dir_drive_a: assert property (wr_take(4'h3) |=> ##1
    line_pin.oe == $past(avs_writedata[7:0])) else $error("pin enable wrong");
  en_gate_a: assert property (wr_take(4'h2) ##0 !avs_writedata[7] |=> ##1
    !expander_host_irq.req) else $error("request despite disable");
  exp_mask_a: assert property (wr_take(4'h0) ##0 !avs_writedata[0] |=> ##1
    !expander_host_irq.req) else $error("request despite mask");
  line_mask_a: assert property (wr_take(4'h7) ##0 avs_writedata[7:0] == 8'h00 |=> ##1
    !line_irq) else $error("line request despite mask");
  plat_rst_a: assert property (disable iff (1'b0) !reset_n |=>
    !line_irq && expander_host_irq == 4'h0) else $error("requests not reset");
  keep_cfg_a: assert property (disable iff (!power_on_reset_n)
    !reset_n && power_retention_select |=> $stable(line_pin)) else $error("pins lost");
  cfg_rst_a: assert property (disable iff (1'b0)
    (!reset_n && !power_retention_select) || !power_on_reset_n |=> line_pin == 16'h0000)
    else $error("pins not reset");
endmodule
bind gpirq_port gpirq_port_asserts u_chk (.clk, .reset_n, .power_on_reset_n,
  .power_retention_select, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .line_pin_in, .line_pin, .expander_irq_in,
  .expander_host_irq, .line_irq);

/* File: verif/gpirq_pins_model.sv */
// behavioural model of the outside lines and the expander interrupt
`timescale 1ns/1ps
module gpirq_pins_model (
  // port drive and the outside devices' own levels
  input wire gpirq_pkg::gpirq_pin_drive_type line_pin,
  input wire logic [7:0] ext_level,
  input wire logic exp_level,
  // resolved levels back into the port
  output logic [7:0] line_pin_in,
  output logic expander_irq_in
);
  // a driven line follows the port, an undriven one the outside device
  assign line_pin_in = (line_pin.oe & line_pin.out) | (~line_pin.oe & ext_level);
  // both expanders share one wire, held where the bench puts it
  assign expander_irq_in = exp_level;
endmodule

/* File: verif/gpirq_port_tb_top.sv */
// self-checking bench for the gpio interrupt port
`timescale 1ns/1ps
module gpirq_port_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic por_n = 1'b0;
  logic ret = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [7:0] pin_in;
  logic [7:0] ext = 8'h00;
  logic exp_lvl = 1'b0;
  logic exp_in;
  gpirq_pkg::gpirq_pin_drive_type pins;
  gpirq_pkg::gpirq_host_irq_type hirq;
  logic lirq;
  logic [31:0] v;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  gpirq_port u_dut (.clk(clk), .reset_n(reset_n), .power_on_reset_n(por_n),
    .power_retention_select(ret), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq), .line_pin_in(pin_in),
    .line_pin(pins), .expander_irq_in(exp_in), .expander_host_irq(hirq), .line_irq(lirq));
  gpirq_pins_model u_far (.line_pin(pins), .ext_level(ext), .exp_level(exp_lvl),
    .line_pin_in(pin_in), .expander_irq_in(exp_in));
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hung handshake ends the run here
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] e);
    n_compared++;
    if (seen !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, seen);
    end
  endtask
  // one bus cycle, held until waitrequest is sampled low; gap edge avoids back-to-back races
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    adr <= a;
    wdat <= {24'h0, d};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wreq) @(posedge clk);
    v = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(what, v, {24'h0, e});
  endtask
  task automatic pulse(input logic keep, input logic por);
    ret <= keep;
    reset_n <= 1'b0;
    por_n <= !por;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic t_defaults();
    for (int i = 0; i < 10; i++)
      rchk("reset value", (i == 9) ? 4'hf : 4'(i), 8'h00);
    bus(1'b1, 4'h0, 8'hff);
    rchk("mask reserved", 4'h0, 8'h01);
    bus(1'b1, 4'h2, 8'h7f);
    rchk("control reserved", 4'h2, 8'h70);
    bus(1'b1, 4'h6, 8'hff);
    rchk("readback read only", 4'h6, 8'h00);
  endtask
  task automatic t_expander();
    bus(1'b1, 4'h2, 8'h80);
    exp_lvl <= 1'b1;
    repeat (6) @(posedge clk);
    check("host request", hirq.req, 1'b1);
    bus(1'b1, 4'h1, 8'h00);
    rchk("status kept", 4'h1, 8'h01);
    for (int s = 0; s < 8; s++)
    begin
      bus(1'b1, 4'h2, {1'b1, 3'(s), 4'h0});
      check("irq line", {hirq.req, hirq.line}, {1'b1, 3'(s)});
    end
    bus(1'b1, 4'h2, 8'h00);
    check("disabled request", hirq.req, 1'b0);
    bus(1'b1, 4'h2, 8'h80);
    check("request before clear", hirq.req, 1'b1);
    bus(1'b1, 4'h1, 8'h01);
    rchk("status cleared", 4'h1, 8'h00);
    check("request dropped", hirq.req, 1'b0);
    exp_lvl <= 1'b0;
    bus(1'b1, 4'h0, 8'h00);
  endtask
  task automatic t_lines();
    bus(1'b1, 4'h3, 8'h0f);
    bus(1'b1, 4'h4, 8'h33);
    bus(1'b1, 4'h5, 8'h55);
    ext <= 8'ha0;
    repeat (4) @(posedge clk);
    check("pin enable", pins.oe, 8'h0f);
    check("pin drive", pins.out, 8'h66);
    rchk("stored output", 4'h5, 8'h55);
    rchk("input readback", 4'h6, 8'h95);
    bus(1'b1, 4'h3, 8'h00);
    bus(1'b1, 4'h7, 8'hff);
    repeat (6) @(posedge clk);
    bus(1'b1, 4'h8, 8'hff);
    rchk("line status clear", 4'h8, 8'h00);
    ext <= 8'h5f;
    repeat (6) @(posedge clk);
    rchk("line edges", 4'h8, 8'h6c);
    check("line request", lirq, 1'b1);
    bus(1'b1, 4'h8, 8'h0c);
    rchk("line status w1c", 4'h8, 8'h60);
    bus(1'b1, 4'h7, 8'h0c);
    check("masked request", lirq, 1'b0);
    bus(1'b1, 4'h7, 8'h20);
    check("unmasked request", lirq, 1'b1);
    bus(1'b1, 4'h7, 8'h00);
  endtask
  task automatic t_retain();
    bus(1'b1, 4'h7, 8'hff);
    bus(1'b1, 4'h3, 8'hff);
    pulse(1'b1, 1'b0);
    check("kept enable", pins.oe, 8'hff);
    rchk("kept direction", 4'h3, 8'hff);
    rchk("mask reset", 4'h7, 8'h00);
    pulse(1'b0, 1'b0);
    rchk("direction reset", 4'h3, 8'h00);
    bus(1'b1, 4'h3, 8'hff);
    pulse(1'b1, 1'b1);
    rchk("power-on reset", 4'h3, 8'h00);
  endtask
  // reset for twelve cycles, then the scenarios in turn
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_expander();
    t_lines();
    t_retain();
    summarize();
  end
endmodule
